// ---- bench/sfs_src_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Sample source: offers len samples, each held until taken
module sfs_src_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Command
   input wire logic start,
   input wire logic [7:0] len,
   // Sample port
   input wire logic sample_ready,
   output logic sample_valid,
   output logic [15:0] sample_x,
   output logic [15:0] sample_y,
   output logic [15:0] sample_z,
   output logic [7:0] n
);
   logic [7:0] left;
   // Count down offers, number samples in order taken
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         left <= 8'h00;
         n <= 8'h00;
      end
      else if (start)
         left <= len;
      else if (sample_valid && sample_ready)
      begin
         left <= left - 8'h01;
         n <= n + 8'h01;
      end
   end
   // Idle lines show the inverse so stale data is never mistaken for new
   assign sample_valid = left != 8'h00;
   assign sample_x = sample_valid ? {8'h10, n} : ~{8'h10, n};
   assign sample_y = sample_valid ? {8'h20, n} : ~{8'h20, n};
   assign sample_z = sample_valid ? {8'h30, n} : ~{8'h30, n};
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
// ==========================================================
// Bench for the sample buffer
module tb_top;
   import sfs_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [1:0] mode = 2'h1;
   logic [4:0] samples = 5'h04;
   logic trigger_in = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic xfer_end = 1'b0;
   logic start = 1'b0;
   logic [7:0] len = 8'h00;
   logic sample_ready, sample_valid, watermark, flag;
   logic [15:0] sx, sy, sz;
   logic [7:0] reg_rdata, n, d;
   int err_count = 0;
   int compares = 0;
   always #5 mclk = ~mclk;
   sfs_buffer u_dut (.mclk(mclk), .arst_n(arst_n), .mode(mode), .samples(samples),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_x(sx), .sample_y(sy),
      .sample_z(sz), .trigger_in(trigger_in), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .xfer_end(xfer_end), .reg_rdata(reg_rdata), .watermark(watermark), .trigger_occurred_flag(flag));
   sfs_src_model u_src (.mclk(mclk), .arst_n(arst_n), .start(start), .len(len),
      .sample_ready(sample_ready), .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy),
      .sample_z(sz), .n(n));
   // ==========================================================
   // Tasks
   task automatic results;
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reset_to(input logic [1:0] m);
      @(posedge mclk);
      arst_n <= 1'b0;
      mode <= m;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
   endtask
   // One byte read; data lands the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic xfer;
      @(posedge mclk);
      xfer_end <= 1'b1;
      @(posedge mclk);
      xfer_end <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic st(input logic [7:0] exp);
      rd(SFS_BUFFER_STATUS_ADDR, d);
      chk("status", d, exp);
   endtask
   task automatic send(input logic [7:0] k, input logic [7:0] upto);
      @(posedge mclk);
      start <= 1'b1;
      len <= k;
      @(posedge mclk);
      start <= 1'b0;
      for (int i = 0; i < 200 && n != upto; i++)
         @(posedge mclk);
      if (n != upto)
      begin
         err_count++;
         results();
      end
      @(posedge mclk);
   endtask
   // Whole level in one transaction: x, y, z low then high byte
   task automatic burst(input logic [7:0] s);
      for (int i = 0; i < SFS_DATA_BYTES; i++)
      begin
         rd(SFS_DATA_BASE_ADDR + 8'(i), d);
         chk("data", d, i % 2 ? 8'(16 * (i / 2 + 1)) : s);
      end
      xfer();
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      reset_to(SFS_MODE_FIFO);
      st(8'h00);
      send(8'd34, 8'd33);
      chk("ready", {7'h0, sample_ready}, 8'h00);
      st(8'h21);
      st(8'h21);
      burst(8'h00);
      send(8'd0, 8'd34);
      st(8'h21);
      // Single byte read still pops the level
      rd(SFS_DATA_BASE_ADDR, d);
      chk("single", d, 8'h01);
      xfer();
      st(8'h20);
      rd(8'h00, d);
      chk("unmapped", d, 8'h00);
      // Watermark at the sample count in stream mode
      reset_to(SFS_MODE_STREAM);
      send(8'd3, 8'd3);
      chk("watermark", {7'h0, watermark}, 8'h00);
      send(8'd1, 8'd4);
      chk("watermark", {7'h0, watermark}, 8'h01);
      // History kept before the trigger, then the flag
      reset_to(SFS_MODE_TRIGGER);
      send(8'd10, 8'd10);
      st(8'h04);
      chk("flag", {7'h0, flag}, 8'h00);
      @(posedge mclk);
      trigger_in <= 1'b1;
      @(posedge mclk);
      trigger_in <= 1'b0;
      @(posedge mclk);
      chk("flag", {7'h0, flag}, 8'h01);
      st(8'h84);
      burst(8'h06);
      // Bypass keeps only the newest sample in the stage
      reset_to(SFS_MODE_BYPASS);
      send(8'd3, 8'd3);
      st(8'h01);
      burst(8'h02);
      st(8'h00);
      rd(SFS_DATA_BASE_ADDR, d);
      chk("empty", d, 8'h00);
      results();
   end
endmodule

// ---- hw/sfs_buffer.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Sample store fifo
module sfs_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [$clog2(DEPTH+1)-1:0] cnt;
   } sfs_fifo_st_t;
   sfs_fifo_st_t st;
   sfs_fifo_st_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic do_push;
   logic do_pop;

   // Full accepts a push only alongside a pop, so overwrite-oldest works
   assign out_valid = (st.cnt != '0);
   assign in_ready = (st.cnt != CW'(DEPTH)) || out_ready;
   assign out_data = mem[st.rptr];
   assign count = st.cnt;
   assign do_push = in_valid && in_ready;
   assign do_pop = out_valid && out_ready;

   // Pointer and level update
   always_comb
   begin
      next_st = st;
      if (do_push)
         next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
      if (do_pop)
         next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
      next_st.cnt = st.cnt + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         st <= '0;
      else
         st <= next_st;
   end

   // Storage holds no reset, contents are qualified by the level
   always_ff @(posedge mclk)
   begin
      if (do_push)
         mem[st.wptr] <= in_data;
   end

   // ==========================================================================
   // Assertions
   default clocking fcb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // Level moves by one for an unpaired push or pop, never past the depth
   fifo_level_a: assert property (st.cnt <= CW'(DEPTH))
      else $error("store level beyond depth");
   fifo_rise_a: assert property (do_push && !do_pop |=> st.cnt == $past(st.cnt) + 1'b1)
      else $error("store level did not rise");
   fifo_fall_a: assert property (do_pop && !do_push |=> st.cnt == $past(st.cnt) - 1'b1)
      else $error("store level did not fall");
   // First word into an empty store appears at the head a cycle later
   fifo_head_a: assert property (do_push && st.cnt == '0 |=> out_data == $past(in_data))
      else $error("store head word wrong");
endmodule

// ==========================================================================
// Sample buffer with status readout
// What this block does
// - Stream mode: sample count sets watermark level
// - Trigger mode: sample count sets pre-trigger history
// - Status D7 shows trigger has occurred
// - Status low bits count held entries; D6 zero
// - Samples read through axis data registers
// - A transaction with any data register read removes one level at its end
// - 32 stored plus one output stage, 33
module sfs_buffer #(
   parameter int DEPTH = sfs_pkg::SFS_DEPTH,
   parameter int SAMPLE_W = sfs_pkg::SFS_SAMPLE_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Configuration
   input wire logic [1:0] mode,
   input wire logic [sfs_pkg::SFS_COUNT_W-1:0] samples,
   // Sample source
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [SAMPLE_W-1:0] sample_x,
   input wire logic [SAMPLE_W-1:0] sample_y,
   input wire logic [SAMPLE_W-1:0] sample_z,
   input wire logic trigger_in,
   // Register read port
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic xfer_end,
   output logic [7:0] reg_rdata,
   // Status
   output logic watermark,
   output logic trigger_occurred_flag
);
   import sfs_pkg::*;
   localparam int W = 3 * SAMPLE_W;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic stage_valid;
      logic [W-1:0] stage;
      logic trig;
      logic touched;
      logic [7:0] rdata;
   } sfs_state_t;
   sfs_state_t st;
   sfs_state_t next_st;

   logic f_in_valid;
   logic f_in_ready;
   logic f_out_valid;
   logic f_out_ready;
   logic [W-1:0] f_out_data;
   logic [CW-1:0] f_count;
   logic [SFS_ENTRIES_W-1:0] entries;
   logic [W-1:0] new_sample;
   logic is_data_addr;
   logic pop_now;
   logic drop;
   logic stream_like;
   logic pre_trig;
   logic stage_free;
   logic to_stage;
   logic bypass;

   // Byte select of the output stage for one data register address
   function automatic logic [7:0] data_byte(input logic [W-1:0] s, input logic [7:0] a);
      logic [7:0] idx;
      idx = a - SFS_DATA_BASE_ADDR;
      data_byte = s[idx[2:0]*8 +: 8];
   endfunction

   // Store shares the same depth; the output stage is the extra entry
   sfs_fifo #(
      .WIDTH(W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .arst_n(arst_n),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(new_sample),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data),
      .count(f_count)
   );

   // Flow control around the store and the output stage
   assign new_sample = {sample_z, sample_y, sample_x};
   assign bypass = (mode == SFS_MODE_BYPASS);
   assign pre_trig = (mode == SFS_MODE_TRIGGER) && !st.trig;
   assign stream_like = (mode == SFS_MODE_STREAM) || pre_trig;
   assign entries = SFS_ENTRIES_W'(f_count) + SFS_ENTRIES_W'(st.stage_valid);
   assign is_data_addr = (reg_addr >= SFS_DATA_BASE_ADDR) &&
                         (reg_addr < SFS_DATA_BASE_ADDR + 8'(SFS_DATA_BYTES));
   assign pop_now = xfer_end && st.touched && st.stage_valid;
   // Drop oldest on overflow, or to keep only the pre-trigger history
   assign drop = sample_valid && st.stage_valid && stream_like &&
                 ((f_count == CW'(DEPTH)) ||
                  (pre_trig && entries >= SFS_ENTRIES_W'(samples)));
   assign stage_free = !st.stage_valid || pop_now || drop || bypass;
   assign to_stage = sample_valid && !f_out_valid && stage_free;
   assign f_out_ready = f_out_valid && stage_free;
   assign f_in_valid = sample_valid && !bypass && !to_stage;
   // Fifo mode and post-trigger stop accepting once full
   assign sample_ready = bypass || to_stage || f_in_ready;
   assign watermark = (mode == SFS_MODE_FIFO || mode == SFS_MODE_STREAM) &&
                      (samples != '0) && (entries >= SFS_ENTRIES_W'(samples));
   assign trigger_occurred_flag = st.trig;
   assign reg_rdata = st.rdata;

   // Next state of stage, trigger flag and read data
   always_comb
   begin
      next_st = st;
      if (f_out_ready)
      begin
         next_st.stage = f_out_data;
         next_st.stage_valid = 1'b1;
      end
      else if (to_stage || (bypass && sample_valid))
      begin
         next_st.stage = new_sample;
         next_st.stage_valid = 1'b1;
      end
      else if (pop_now)
         next_st.stage_valid = 1'b0;
      if (mode != SFS_MODE_TRIGGER)
         next_st.trig = 1'b0;
      else if (trigger_in)
         next_st.trig = 1'b1;
      if (xfer_end)
         next_st.touched = 1'b0;
      else if (reg_rd && is_data_addr)
         next_st.touched = 1'b1;
      if (reg_rd)
      begin
         if (reg_addr == SFS_BUFFER_STATUS_ADDR)
            next_st.rdata = {st.trig, 1'b0, entries};
         else if (is_data_addr)
            next_st.rdata = st.stage_valid ? data_byte(st.stage, reg_addr) : 8'h00;
         else
            next_st.rdata = 8'h00;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '0;
         st.rdata <= SFS_RDATA_RST;
      end
      else
         st <= next_st;
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // Host read of the status register
   sequence status_read_s;
      reg_rd && reg_addr == SFS_BUFFER_STATUS_ADDR;
   endsequence
   // Host burst: a data read, then the transaction end one or two cycles on
   sequence data_burst_s;
      reg_rd && is_data_addr && !xfer_end ##1
         (xfer_end or (!xfer_end ##1 xfer_end));
   endsequence

   status_trig_a: assert property (status_read_s |=> reg_rdata[SFS_TRIG_BIT] == $past(st.trig))
      else $error("status trigger bit wrong");
   status_zero_a: assert property (status_read_s |=> reg_rdata[SFS_ZERO_BIT] == 1'b0)
      else $error("status bit six not zero");
   status_count_a: assert property (status_read_s |=> reg_rdata[5:0] == $past(entries))
      else $error("status entry count wrong");
   status_nopop_a: assert property ((status_read_s and (!xfer_end && !sample_valid)) |=> $stable(entries))
      else $error("status read changed buffer");
   burst_pop_a: assert property (data_burst_s ##0 (st.stage_valid && !sample_valid && !f_out_valid)
                                 |=> !st.stage_valid)
      else $error("level not removed after data read");
   entries_max_a: assert property (entries <= SFS_ENTRIES_W'(DEPTH + 1))
      else $error("entry count beyond limit");
   wm_level_a: assert property (mode == SFS_MODE_STREAM && samples != '0 &&
                                entries >= SFS_ENTRIES_W'(samples) |-> watermark)
      else $error("watermark missing in stream mode");
   pretrig_cap_a: assert property (pre_trig && samples != '0 && $stable(samples) && $stable(mode) &&
                                   $past(entries) <= SFS_ENTRIES_W'(samples)
                                   |-> entries <= SFS_ENTRIES_W'(samples))
      else $error("pre-trigger history exceeds setting");
   data_byte_a: assert property (reg_rd && is_data_addr && st.stage_valid
                                 |=> reg_rdata == data_byte($past(st.stage), $past(reg_addr)))
      else $error("data register byte wrong");

   // Buffer level, trigger flag and read data outside the status checks
   pop_step_a: assert property (pop_now && !sample_valid |=> entries == $past(entries) - SFS_ENTRIES_W'(1))
      else $error("level not reduced by one");
   full_stall_a: assert property (mode == SFS_MODE_FIFO && !xfer_end && entries == SFS_ENTRIES_W'(DEPTH + 1)
                                  |-> !sample_ready)
      else $error("sample taken while buffer full");
   // The flag must stick while the mode stays, or a slow host misses it
   trig_rise_a: assert property (mode == SFS_MODE_TRIGGER && trigger_in ##1 mode == SFS_MODE_TRIGGER
                                 |-> trigger_occurred_flag)
      else $error("trigger flag not set");
   trig_hold_a: assert property (trigger_occurred_flag && mode == SFS_MODE_TRIGGER ##1 mode == SFS_MODE_TRIGGER
                                 |-> trigger_occurred_flag)
      else $error("trigger flag lost");
   empty_data_a: assert property (reg_rd && is_data_addr && !st.stage_valid |=> reg_rdata == 8'h00)
      else $error("empty buffer read not zero");
   unmapped_zero_a: assert property (reg_rd && !is_data_addr && reg_addr != SFS_BUFFER_STATUS_ADDR
                                     |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // Read data stands until the next strobe, so slow hosts can sample it
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule

// ---- hw/sfs_pkg.sv ----
package sfs_pkg;
   // Register map, byte addresses
   localparam logic [7:0] SFS_BUFFER_STATUS_ADDR = 8'h39;
   localparam logic [7:0] SFS_DATA_BASE_ADDR = 8'h32;
   localparam int SFS_DATA_BYTES = 6;
   // Status field layout
   localparam int SFS_TRIG_BIT = 7;
   localparam int SFS_ZERO_BIT = 6;
   localparam int SFS_ENTRIES_W = 6;
   // Buffer sizing
   localparam int SFS_DEPTH = 32;
   localparam int SFS_SAMPLE_W = 16;
   localparam int SFS_COUNT_W = 5;
   // Buffer modes
   localparam logic [1:0] SFS_MODE_BYPASS = 2'h0;
   localparam logic [1:0] SFS_MODE_FIFO = 2'h1;
   localparam logic [1:0] SFS_MODE_STREAM = 2'h2;
   localparam logic [1:0] SFS_MODE_TRIGGER = 2'h3;
   // Reset values
   localparam logic [7:0] SFS_RDATA_RST = 8'h00;
endpackage
